// ==== hw/tmcp_pkg.sv ====
package tmcp_pkg;

  // ------------------------------------------------------------
  // Command codes
  // ------------------------------------------------------------
  localparam logic [7:0] CMD_GET        = 8'h67;
  localparam logic [7:0] CMD_PUT        = 8'h70;
  localparam logic [7:0] CMD_SCOPE_KEY  = 8'h73;
  localparam logic [7:0] CMD_SCOPE_ALL  = 8'h53;
  localparam logic [7:0] CMD_SCOPE_ROW  = 8'h78;
  localparam logic [7:0] CMD_SCOPE_COL  = 8'h79;
  localparam logic [7:0] CMD_KEY_BASE   = 8'h30;
  localparam logic [7:0] CMD_KEY_LAST   = 8'h35;
  localparam logic [7:0] CMD_CHECKSUM   = 8'h36;
  localparam logic [7:0] CMD_DEV_STATUS = 8'h37;
  localparam logic [7:0] CMD_GRP_BASE   = 8'h20;
  localparam logic [7:0] CMD_GRP_LAST   = 8'h25;
  localparam logic [7:0] CMD_ERR_KEY    = 8'h65;
  localparam logic [7:0] CMD_ERR_GRP    = 8'h45;
  localparam logic [7:0] CMD_FIRST_KEY  = 8'h6B;
  localparam logic [7:0] CMD_TOUCH_GRP  = 8'h4B;

  // ------------------------------------------------------------
  // Quantity selectors, limits and fixed values
  // ------------------------------------------------------------
  localparam logic [2:0] QTY_SIGNAL = 3'h0;
  localparam logic [2:0] QTY_DELTA  = 3'h1;
  localparam logic [2:0] QTY_REF    = 3'h2;
  localparam logic [2:0] QTY_DAC    = 3'h3;
  localparam logic [2:0] QTY_CAP    = 3'h4;
  localparam logic [2:0] QTY_INTEG  = 3'h5;
  localparam logic [2:0] QTY_ERR    = 3'h6;
  localparam logic [2:0] QTY_TOUCH  = 3'h7;

  localparam logic [7:0] CAP_MAX      = 8'h02;
  localparam logic [7:0] ERR_MASK     = 8'h0F;
  localparam logic [7:0] STATUS_MASK  = 8'h1F;
  localparam logic [5:0] KEY_MAX      = 6'h3F;
  localparam logic [2:0] LINE_MAX     = 3'h7;
  localparam logic [7:0] NO_TOUCH     = 8'hFF;
  localparam logic [7:0] IDLE_REPLY   = 8'h00;
  localparam logic [6:0] CNT_ONE      = 7'h01;
  localparam logic [6:0] CNT_LINE     = 7'h08;
  localparam logic [6:0] CNT_ALL      = 7'h40;
  localparam logic [2:0] BIT_LAST     = 3'h7;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    SCOPE_KEY = 2'h0,
    SCOPE_ROW = 2'h1,
    SCOPE_COL = 2'h2,
    SCOPE_ALL = 2'h3
  } tmcp_scope_mode_t;

  typedef struct packed {
    tmcp_scope_mode_t mode;
    logic [5:0]       idx;
  } tmcp_scope_t;

  typedef struct packed {
    logic [7:0] signal;
    logic [7:0] reference;
    logic [7:0] ladder_dac_offset;
    logic [7:0] integrator_cap_state;
    logic [7:0] det_integrator;
    logic [7:0] err_code;
  } tmcp_key_meas_t;

  typedef enum logic [2:0] {
    ST_CMD    = 3'b001,
    ST_OPND   = 3'b010,
    ST_STREAM = 3'b100
  } tmcp_state_t;

endpackage

// ==== hw/tmcp_parser.sv ====
`timescale 1ns/1ps
module tmcp_parser
  import tmcp_pkg::*;
(
  input  wire logic           i_clk_sys,
  input  wire logic           i_nrst,
  input  wire logic           i_ce,
  input  wire logic           i_spi_sck,
  input  wire logic           i_spi_ss_n,
  input  wire logic           i_spi_mosi,
  input  wire tmcp_key_meas_t i_key_meas,
  input  wire logic [63:0]    i_touch,
  input  wire logic [7:0]     i_checksum,
  input  wire logic [7:0]     i_dev_status,
  output logic                o_spi_miso,
  output logic                o_dir_put,
  output tmcp_scope_t         o_scope,
  output logic [5:0]          o_meas_key
);

  // ------------------------------------------------------------
  // Reset release and pin synchronisers
  // ------------------------------------------------------------
  logic       rst_m_q, rst_n_q;
  logic [2:0] sck_q, ss_q, mosi_q;

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_m_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_n_q <= rst_m_q;
    end
  end

  // The third stage only feeds the edge detectors; the first stage feeds nothing else.
  always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sck_q  <= 3'h0;
      ss_q   <= 3'h7;
      mosi_q <= 3'h0;
    end else if (i_ce) begin
      sck_q  <= {sck_q[1:0], i_spi_sck};
      ss_q   <= {ss_q[1:0], i_spi_ss_n};
      mosi_q <= {mosi_q[1:0], i_spi_mosi};
    end
  end

  logic in_frame, sck_rise, sck_fall, frame_start;
  assign in_frame    = !ss_q[1];
  assign sck_rise    = in_frame && sck_q[1] && !sck_q[2];
  assign sck_fall    = in_frame && !sck_q[1] && sck_q[2];
  assign frame_start = !ss_q[1] && ss_q[2];

  // ------------------------------------------------------------
  // Byte receive and reply shifter
  // ------------------------------------------------------------
  logic [2:0] bit_q;
  logic [7:0] rx_q, tx_q, reply_q;
  logic       byte_done_q;

  always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      bit_q       <= 3'h0;
      rx_q        <= 8'h00;
      byte_done_q <= 1'b0;
    end else if (i_ce) begin
      byte_done_q <= 1'b0;
      if (!in_frame) begin
        bit_q <= 3'h0;
      end else if (sck_rise) begin
        rx_q  <= {rx_q[6:0], mosi_q[1]};
        bit_q <= bit_q + 3'h1;
        byte_done_q <= (bit_q == BIT_LAST);
      end
    end
  end

  // A byte's reply goes out during the next exchange; the MSB is set up on the edge before it.
  always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tx_q       <= 8'h00;
      o_spi_miso <= 1'b0;
    end else if (i_ce) begin
      if (frame_start || (sck_fall && bit_q == 3'h0)) begin
        o_spi_miso <= reply_q[7];
        tx_q       <= {reply_q[6:0], 1'b0};
      end else if (sck_fall) begin
        o_spi_miso <= tx_q[7];
        tx_q       <= {tx_q[6:0], 1'b0};
      end
    end
  end

  // ------------------------------------------------------------
  // Command decode
  // ------------------------------------------------------------
  function automatic logic [5:0] elem_key(input tmcp_scope_t sc, input logic [5:0] n);
    case (sc.mode)
      SCOPE_ROW: elem_key = {sc.idx[2:0], n[2:0]};
      SCOPE_COL: elem_key = {n[2:0], sc.idx[2:0]};
      SCOPE_ALL: elem_key = n;
      default:   elem_key = sc.idx;
    endcase
  endfunction

  function automatic logic [6:0] scope_cnt(input tmcp_scope_t sc);
    case (sc.mode)
      SCOPE_ROW, SCOPE_COL: scope_cnt = CNT_LINE;
      SCOPE_ALL:            scope_cnt = CNT_ALL;
      default:              scope_cnt = CNT_ONE;
    endcase
  endfunction

  function automatic logic [7:0] first_touch(input logic [63:0] t);
    first_touch = NO_TOUCH;
    for (int i = 63; i >= 0; i--) begin
      if (t[i]) begin
        first_touch = 8'(i);
      end
    end
  endfunction

  tmcp_state_t state_q;
  logic [7:0]  opcode_q;
  logic [2:0]  qty_q;
  logic        fetch_q;
  logic [6:0]  remain_q, elem_q;
  logic        take_cmd, take_opnd, take_fill;
  logic        is_key, is_err_key, is_grp, is_scope_op;

  assign take_cmd    = byte_done_q && (state_q == ST_CMD);
  assign take_opnd   = byte_done_q && (state_q == ST_OPND);
  assign take_fill   = byte_done_q && (state_q == ST_STREAM);
  assign is_key      = (rx_q >= CMD_KEY_BASE) && (rx_q <= CMD_KEY_LAST);
  assign is_err_key  = (rx_q == CMD_ERR_KEY);
  assign is_grp      = ((rx_q >= CMD_GRP_BASE) && (rx_q <= CMD_GRP_LAST)) ||
                       (rx_q == CMD_ERR_GRP) || (rx_q == CMD_TOUCH_GRP);
  assign is_scope_op = (rx_q == CMD_SCOPE_KEY) || (rx_q == CMD_SCOPE_ROW) || (rx_q == CMD_SCOPE_COL);

  // ------------------------------------------------------------
  // Direction
  // ------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      o_dir_put <= 1'b0;
    end else if (i_ce && take_cmd) begin
      if (rx_q == CMD_GET) begin
        o_dir_put <= 1'b0;
      end else if (rx_q == CMD_PUT) begin
        o_dir_put <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Scope
  // ------------------------------------------------------------
  // Out-of-range operands are folded into range rather than rejected.
  always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      o_scope <= '{mode: SCOPE_KEY, idx: 6'h00};
    end else if (i_ce) begin
      if (take_cmd && (rx_q == CMD_SCOPE_ALL)) begin
        o_scope <= '{mode: SCOPE_ALL, idx: 6'h00};
      end else if (take_opnd) begin
        case (opcode_q)
          CMD_SCOPE_ROW: o_scope <= '{mode: SCOPE_ROW, idx: {3'h0, rx_q[2:0] & LINE_MAX}};
          CMD_SCOPE_COL: o_scope <= '{mode: SCOPE_COL, idx: {3'h0, rx_q[2:0] & LINE_MAX}};
          default:       o_scope <= '{mode: SCOPE_KEY, idx: rx_q[5:0] & KEY_MAX};
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Measurement key
  // ------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      o_meas_key <= 6'h00;
    end else if (i_ce) begin
      if (take_cmd && (is_key || is_err_key)) begin
        o_meas_key <= o_scope.idx;
      end else if (take_cmd && is_grp) begin
        o_meas_key <= elem_key(o_scope, 6'h00);
      end else if (take_fill) begin
        o_meas_key <= elem_key(o_scope, elem_q[5:0]);
      end
    end
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q  <= ST_CMD;
      opcode_q <= 8'h00;
      qty_q    <= QTY_SIGNAL;
      fetch_q  <= 1'b0;
      remain_q <= 7'h00;
      elem_q   <= 7'h00;
    end else if (i_ce) begin
      fetch_q <= 1'b0;
      if (take_opnd) begin
        state_q <= ST_CMD;
      end else if (take_fill) begin
        // Bytes clocked in during a group reply are fillers and are not decoded.
        elem_q   <= elem_q + 7'h01;
        remain_q <= remain_q - 7'h01;
        fetch_q  <= 1'b1;
        if (remain_q == CNT_ONE) begin
          state_q <= ST_CMD;
        end
      end else if (take_cmd) begin
        opcode_q <= rx_q;
        if (is_scope_op) begin
          state_q <= ST_OPND;
        end else if (is_key) begin
          qty_q   <= 3'(rx_q - CMD_KEY_BASE);
          fetch_q <= 1'b1;
        end else if (is_err_key) begin
          qty_q   <= QTY_ERR;
          fetch_q <= 1'b1;
        end else if (is_grp) begin
          if (rx_q == CMD_ERR_GRP) begin
            qty_q <= QTY_ERR;
          end else if (rx_q == CMD_TOUCH_GRP) begin
            qty_q <= QTY_TOUCH;
          end else begin
            qty_q <= 3'(rx_q - CMD_GRP_BASE);
          end
          elem_q   <= CNT_ONE;
          fetch_q  <= 1'b1;
          remain_q <= scope_cnt(o_scope) - 7'h01;
          if (scope_cnt(o_scope) != CNT_ONE) begin
            state_q <= ST_STREAM;
          end
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Reply
  // ------------------------------------------------------------
  // A fetch lands one cycle after the key index moves, so the store has a cycle to answer.
  always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      reply_q <= IDLE_REPLY;
    end else if (i_ce) begin
      if (fetch_q) begin
        case (qty_q)
          QTY_SIGNAL: reply_q <= i_key_meas.signal;
          QTY_DELTA:  reply_q <= i_key_meas.reference - i_key_meas.signal;
          QTY_REF:    reply_q <= i_key_meas.reference;
          QTY_DAC:    reply_q <= i_key_meas.ladder_dac_offset;
          QTY_CAP:    reply_q <= (i_key_meas.integrator_cap_state > CAP_MAX) ?
                                 CAP_MAX : i_key_meas.integrator_cap_state;
          QTY_INTEG:  reply_q <= i_key_meas.det_integrator;
          QTY_ERR:    reply_q <= i_key_meas.err_code & ERR_MASK;
          default:    reply_q <= {7'h00, i_touch[o_meas_key]};
        endcase
      end else if (take_opnd) begin
        reply_q <= opcode_q;
      end else if (take_cmd) begin
        if ((rx_q == CMD_GET) || (rx_q == CMD_PUT) || (rx_q == CMD_SCOPE_ALL)) begin
          reply_q <= rx_q;
        end else if (rx_q == CMD_CHECKSUM) begin
          reply_q <= i_checksum;
        end else if (rx_q == CMD_DEV_STATUS) begin
          reply_q <= i_dev_status & STATUS_MASK;
        end else if (rx_q == CMD_FIRST_KEY) begin
          reply_q <= first_touch(i_touch);
        end else begin
          reply_q <= IDLE_REPLY;
        end
      end
    end
  end

endmodule

// ==== test/tmcp_parser_properties.sv ====
`timescale 1ns/1ps
// --------------------------------
// Port checker
// --------------------------------
module tmcp_parser_chk
  import tmcp_pkg::*;
(
  input wire logic           i_clk_sys,
  input wire logic           i_nrst,
  input wire logic           i_spi_sck,
  input wire logic           i_spi_ss_n,
  input wire logic           o_spi_miso,
  input wire logic           o_dir_put,
  input wire tmcp_scope_t    o_scope,
  input wire logic [5:0]     o_meas_key
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  dir_reset_a: assert property ($rose(i_nrst) |-> !o_dir_put && !o_spi_miso)
    else $error("direction not read after reset");
  scope_reset_a: assert property ($rose(i_nrst) |-> o_scope == 8'h00 && o_meas_key == 6'h00)
    else $error("scope not key zero after reset");
  // No byte can complete while deselected, so nothing may move then.
  dir_idle_a: assert property (i_spi_ss_n [*8] |=> $stable(o_dir_put))
    else $error("direction moved while deselected");
  scope_idle_a: assert property (i_spi_ss_n [*8] |=> $stable(o_scope))
    else $error("scope moved while deselected");
  dir_frame_a: assert property ($changed(o_dir_put) |-> !i_spi_ss_n)
    else $error("direction changed outside a frame");
  scope_frame_a: assert property ($changed(o_scope) |-> !i_spi_ss_n)
    else $error("scope changed outside a frame");
  line_range_a: assert property (o_scope.mode inside {SCOPE_ROW, SCOPE_COL} |-> o_scope.idx[5:3] == 3'h0)
    else $error("row or column index out of range");
  miso_hold_a: assert property ((!i_spi_ss_n && i_spi_sck) [*6] |-> $stable(o_spi_miso))
    else $error("reply bit moved while clock high");
  cover property ($rose(o_dir_put));
  cover property (o_scope.mode == SCOPE_ROW);
  cover property (o_scope.mode == SCOPE_ALL);
endmodule
bind tmcp_parser tmcp_parser_chk u_chk (.i_clk_sys, .i_nrst, .i_spi_sck, .i_spi_ss_n, .o_spi_miso,
  .o_dir_put, .o_scope, .o_meas_key);

// ==== test/tmcp_host_model.sv ====
`timescale 1ns/1ps
// --------------------------------
// Host side of the command port
// --------------------------------
module tmcp_host_model (
  input  wire logic i_miso,
  output logic      o_sck,
  output logic      o_ss_n,
  output logic      o_mosi,
  output logic [7:0] o_rx
);
  event done;
  initial begin
    o_sck = 1'b0;
    o_ss_n = 1'b1;
    o_mosi = 1'b0;
    o_rx = 8'h00;
  end
  // Opcodes, in-range operands and random filler bytes are sent; the put setup is issued once, then get restores read.
  task automatic xfer(input logic [7:0] tx);
    o_ss_n = 1'b0;
    #125;
    for (int i = 7; i >= 0; i--) begin
      o_mosi = tx[i];
      #62.5 o_sck = 1'b1;
      o_rx[i] = i_miso;
      #62.5 o_sck = 1'b0;
    end
    #125 o_ss_n = 1'b1;
    o_mosi = ~o_mosi;
    #125 -> done;
  endtask
endmodule

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
// --------------------------------
// Command port bench
// --------------------------------
module tb_top;
  import tmcp_pkg::*;
  logic           i_clk_sys, i_nrst, sck, ss_n, mosi, miso, dir_put;
  tmcp_key_meas_t meas;
  tmcp_key_meas_t tab [64];
  tmcp_scope_t    scope;
  logic [63:0]    touch;
  logic [7:0]     csum, stat;
  logic [5:0]     mkey, k;
  logic [2:0]     r;
  logic [8:0]     pend;
  logic [8:0]     exp_q [$];
  int             err_count, check_count, cyc;

  tmcp_parser dut (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_ce(1'b1), .i_spi_sck(sck), .i_spi_ss_n(ss_n),
    .i_spi_mosi(mosi), .i_key_meas(meas), .i_touch(touch), .i_checksum(csum), .i_dev_status(stat),
    .o_spi_miso(miso), .o_dir_put(dir_put), .o_scope(scope), .o_meas_key(mkey));
  tmcp_host_model host (.i_miso(miso), .o_sck(sck), .o_ss_n(ss_n), .o_mosi(mosi), .o_rx());

  initial begin
    i_clk_sys = 1'b0;
    forever #2 i_clk_sys = ~i_clk_sys;
  end
  always @(negedge i_clk_sys) meas <= tab[mkey];
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_count++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (err_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // The reply to a byte shows in the next exchange, so each send queues the previous note.
  task automatic cmd(input logic [7:0] tx, input logic [8:0] nxt);
    exp_q.push_back(pend);
    pend = nxt;
    host.xfer(tx);
  endtask
  function automatic logic [7:0] qty(input logic [5:0] n, input logic [2:0] q);
    case (q)
      QTY_SIGNAL: return tab[n].signal;
      QTY_DELTA: return tab[n].reference - tab[n].signal;
      QTY_REF: return tab[n].reference;
      QTY_DAC: return tab[n].ladder_dac_offset;
      QTY_CAP: return (tab[n].integrator_cap_state > CAP_MAX) ? CAP_MAX : tab[n].integrator_cap_state;
      QTY_INTEG: return tab[n].det_integrator;
      QTY_ERR: return tab[n].err_code & ERR_MASK;
      default: return {7'h00, touch[n]};
    endcase
  endfunction
  function automatic logic [7:0] first_touch();
    logic [7:0] f;
    f = NO_TOUCH;
    for (int i = 63; i >= 0; i--) if (touch[i]) f = 8'(i);
    return f;
  endfunction
  task automatic grp(input logic [7:0] c, input logic [2:0] q, input tmcp_scope_mode_t m, input logic [5:0] ix);
    int n;
    logic [5:0] t;
    n = (m == SCOPE_ALL) ? 64 : (m == SCOPE_KEY) ? 1 : 8;
    for (int j = 0; j < n; j++) begin
      t = (m == SCOPE_ROW) ? {ix[2:0], 3'(j)} : (m == SCOPE_COL) ? {3'(j), ix[2:0]} : (m == SCOPE_ALL) ? 6'(j) : ix;
      cmd((j == 0) ? c : 8'($urandom), {1'b0, qty(t, q)});
    end
  endtask

  initial begin
    logic [8:0] e;
    forever begin
      @(host.done);
      e = exp_q.pop_front();
      if (!e[8]) chk(host.o_rx, e[7:0]);
    end
  end

  initial begin
    void'($urandom(83427));
    i_nrst = 1'b0;
    err_count = 0;
    check_count = 0;
    pend = 9'h100;
    for (int i = 0; i < 64; i++) tab[i] = tmcp_key_meas_t'({$urandom, 16'($urandom)});
    touch = {$urandom, $urandom};
    csum = 8'($urandom);
    stat = 8'($urandom);
    repeat (5) @(negedge i_clk_sys);
    i_nrst = 1'b1;
    repeat (6) @(negedge i_clk_sys);
    chk({7'h00, dir_put}, 8'h00);
    chk(scope, 8'h00);
    cmd(CMD_PUT, {1'b0, CMD_PUT});
    chk({7'h00, dir_put}, 8'h01);
    cmd(CMD_GET, {1'b0, CMD_GET});
    chk({7'h00, dir_put}, 8'h00);
    k = 6'($urandom);
    cmd(CMD_SCOPE_KEY, 9'h100);
    cmd({2'b00, k}, {1'b0, CMD_SCOPE_KEY});
    chk(scope, {SCOPE_KEY, k});
    for (int q = 0; q < 7; q++) cmd((q == 6) ? CMD_ERR_KEY : CMD_KEY_BASE + 8'(q), {1'b0, qty(k, 3'(q))});
    cmd(CMD_DEV_STATUS, {1'b0, stat & STATUS_MASK});
    cmd(CMD_FIRST_KEY, {1'b0, first_touch()});
    grp(CMD_ERR_GRP, QTY_ERR, SCOPE_KEY, k);
    grp(CMD_TOUCH_GRP, QTY_TOUCH, SCOPE_KEY, k);
    r = 3'($urandom);
    cmd(CMD_SCOPE_ROW, 9'h100);
    cmd({5'h00, r}, {1'b0, CMD_SCOPE_ROW});
    for (int q = 0; q < 8; q++) grp((q == 6) ? CMD_ERR_GRP : (q == 7) ? CMD_TOUCH_GRP : CMD_GRP_BASE + 8'(q), 3'(q), SCOPE_ROW, {3'h0, r});
    cmd(CMD_SCOPE_COL, 9'h100);
    cmd({5'h00, ~r}, {1'b0, CMD_SCOPE_COL});
    grp(CMD_GRP_BASE + 8'h04, QTY_CAP, SCOPE_COL, {3'h0, ~r});
    cmd(CMD_CHECKSUM, {1'b0, csum});
    cmd(CMD_SCOPE_ALL, {1'b0, CMD_SCOPE_ALL});
    grp(CMD_GRP_BASE + 8'h01, QTY_DELTA, SCOPE_ALL, 6'h00);
    @(negedge i_clk_sys) touch = 64'h0;
    cmd(CMD_FIRST_KEY, {1'b0, NO_TOUCH});
    cmd(8'h7E, 9'h000);
    cmd(8'h7E, 9'h100);
    chk(scope, {SCOPE_ALL, 6'h00});
    repeat (20) @(negedge i_clk_sys);
    finish_test();
  end
endmodule
